// >>> common/alor_regs.svh
// option register field positions, reset value and rate counts
`ifndef ALOR_REGS_SVH
`define ALOR_REGS_SVH
// Function
// - host loads top 12 bits of the 16-bit word on strobe
// - gate pin high forces parity in bit 32
// - loopback low routes transmitter to both receivers
// - receiver two sees inverted loopback stream
// - transmitter pins stay active during loopback
// - receiver one accepts only matching code bits
// - receiver two accepts only matching code bits
// - polarity bit picks odd or even parity
// - transmit rate clock over 10 or 80
// - receive rate clock over 10 or 80
// - word size bit picks 32 or 25
// - low four bits ignored on writes
// - new word size applies from next word
// - receiver one serial word read out as two half words
// - master reset leaves option register unchanged
`define ALOR_OPT_WIDTH 16
`define ALOR_OPT_RESET 16'h0020
`define ALOR_OPT_USED_MASK 16'hFFF0
`define ALOR_BIT_WORD_SIZE 15
`define ALOR_BIT_RECV_RATE 14
`define ALOR_BIT_XMIT_RATE 13
`define ALOR_BIT_PARITY_POL 12
`define ALOR_BIT_LOOPBACK_N 5
`define ALOR_BIT_PARITY_INS 4
`define ALOR_SERIAL_BIT9_IDX 8
`define ALOR_SERIAL_BIT10_IDX 9
`define ALOR_DIV_HI 7'h0A
`define ALOR_DIV_LO 7'h50
`define ALOR_WORD_BITS_LONG 32
`define ALOR_WORD_BITS_SHORT 25
`endif

// >>> common/alor_pkg.sv
// types for the link option register block
package alor_pkg;
    // option word layout, most significant field first
    typedef struct packed {
        logic word_size_pick;
        logic recv_rate_pick;
        logic xmit_rate_pick;
        logic parity_polarity;
        logic rcv_two_code_hi;
        logic rcv_two_code_lo;
        logic rcv_two_match_en;
        logic rcv_one_code_hi;
        logic rcv_one_code_lo;
        logic rcv_one_match_en;
        logic loopback_n;
        logic parity_insert_enable;
        logic [3:0] unused;
    } alor_option_t;

    // per-receiver match settings
    typedef struct packed {
        logic match_en;
        logic code_hi;
        logic code_lo;
    } alor_match_t;

    // strobe capture states
    typedef enum logic [0:0] {
        ALOR_LOAD_IDLE,
        ALOR_LOAD_LOW
    } alor_load_state_t;
endpackage

// >>> design/alor_match_check.sv
// source/destination code check for one receiver
`timescale 1ns/1ns
`include "alor_regs.svh"
module alor_match_check (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // settings and received word
    input wire alor_pkg::alor_match_t match_cfg,
    input wire logic word_done,
    input wire logic [31:0] rcv_word,
    // verdict
    output logic accept
);
    logic accept_reg;
    logic accept_next;
    logic code_ok;

    // disabled check accepts everything
    always_comb begin
        code_ok = (rcv_word[`ALOR_SERIAL_BIT9_IDX] == match_cfg.code_lo) &&
                  (rcv_word[`ALOR_SERIAL_BIT10_IDX] == match_cfg.code_hi);
        accept_next = word_done && (!match_cfg.match_en || code_ok);
    end

    // one-cycle accept pulse
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            accept_reg <= 1'b0;
        end else begin
            accept_reg <= accept_next;
        end
    end

    assign accept = accept_reg;
endmodule

// >>> design/alor_top.sv
// link option register, field decode, rate ticks and loopback routing
`timescale 1ns/1ns
`include "alor_regs.svh"
module alor_top (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // host pins
    input wire logic [15:0] host_data_in,
    input wire logic option_load_n,
    input wire logic parity_gate_n,
    input wire logic master_reset_n,
    // transmitter core, same clock
    input wire logic xmit_serial_a,
    input wire logic xmit_serial_b,
    input wire logic xmit_clk_in,
    input wire logic xmit_word_start,
    input wire logic [31:0] xmit_word,
    // receiver line pins, index 0 is receiver one
    input wire logic [1:0] line_rx_a,
    input wire logic [1:0] line_rx_b,
    // receiver cores, same clock
    input wire logic [1:0] rcv_word_start,
    input wire logic [1:0] rcv_word_done,
    input wire logic [31:0] rcv_word_one,
    input wire logic [31:0] rcv_word_two,
    input wire logic rcv_half_pick,
    // routed receiver inputs
    output logic [1:0] rcv_in_a,
    output logic [1:0] rcv_in_b,
    // transmitter pins
    output logic xmit_pin_a,
    output logic xmit_pin_b,
    output logic xmit_clk_pin,
    // timing ticks
    output logic xmit_bit_tick,
    output logic rcv_sample_tick,
    // decoded settings
    output logic xmit_size_short,
    output logic [1:0] rcv_size_short,
    output logic xmit_bit32,
    output logic [1:0] rcv_accept,
    // half words of receiver one word
    output logic [15:0] half_word_out,
    // live option word for observation
    output alor_pkg::alor_option_t option_view
);
    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic [15:0] data_meta_reg;
    logic [15:0] data_sync_reg;
    logic load_meta_reg;
    logic load_sync_reg;
    logic gate_meta_reg;
    logic gate_sync_reg;
    logic mr_meta_reg;
    logic mr_sync_reg;
    logic [3:0] line_meta_reg;
    logic [3:0] line_sync_reg;

    // two stages on every pin; only stage two is read
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            data_meta_reg <= 16'h0000;
            data_sync_reg <= 16'h0000;
            load_meta_reg <= 1'b1;
            load_sync_reg <= 1'b1;
            gate_meta_reg <= 1'b1;
            gate_sync_reg <= 1'b1;
            mr_meta_reg <= 1'b0;
            mr_sync_reg <= 1'b0;
            line_meta_reg <= 4'h0;
            line_sync_reg <= 4'h0;
        end else begin
            data_meta_reg <= host_data_in;
            data_sync_reg <= data_meta_reg;
            load_meta_reg <= option_load_n;
            load_sync_reg <= load_meta_reg;
            gate_meta_reg <= parity_gate_n;
            gate_sync_reg <= gate_meta_reg;
            mr_meta_reg <= master_reset_n;
            mr_sync_reg <= mr_meta_reg;
            line_meta_reg <= {line_rx_b, line_rx_a};
            line_sync_reg <= line_meta_reg;
        end
    end

    // ************************************************************
    // option register capture
    // ************************************************************
    alor_pkg::alor_load_state_t load_state_reg;
    alor_pkg::alor_load_state_t load_state_next;
    alor_pkg::alor_option_t opt_reg;
    alor_pkg::alor_option_t opt_next;

    // word taken when the strobe rises; master reset plays no part here
    always_comb begin
        load_state_next = load_state_reg;
        opt_next = opt_reg;
        case (load_state_reg)
            alor_pkg::ALOR_LOAD_IDLE: begin
                if (!load_sync_reg) begin
                    load_state_next = alor_pkg::ALOR_LOAD_LOW;
                end
            end
            alor_pkg::ALOR_LOAD_LOW: begin
                if (load_sync_reg) begin
                    load_state_next = alor_pkg::ALOR_LOAD_IDLE;
                    opt_next = alor_pkg::alor_option_t'(data_sync_reg);
                    opt_next.unused = 4'h0;
                end
            end
            default: begin
                load_state_next = alor_pkg::ALOR_LOAD_IDLE;
            end
        endcase
    end

    // only the power-on reset sets the option word
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            load_state_reg <= alor_pkg::ALOR_LOAD_IDLE;
            opt_reg <= alor_pkg::alor_option_t'(`ALOR_OPT_RESET);
        end else begin
            load_state_reg <= load_state_next;
            opt_reg <= opt_next;
        end
    end

    // ************************************************************
    // bit rate dividers
    // ************************************************************
    logic [6:0] xmit_cnt_reg;
    logic [6:0] xmit_cnt_next;
    logic [6:0] rcv_cnt_reg;
    logic [6:0] rcv_cnt_next;
    logic [6:0] xmit_div;
    logic [6:0] rcv_div;
    logic xmit_tick_reg;
    logic xmit_tick_next;
    logic rcv_tick_reg;
    logic rcv_tick_next;

    // master reset holds the counters; a rate change mid-count
    // simply lets the counter wrap at the new limit
    always_comb begin
        xmit_div = opt_reg.xmit_rate_pick ? `ALOR_DIV_LO : `ALOR_DIV_HI;
        rcv_div = opt_reg.recv_rate_pick ? `ALOR_DIV_LO : `ALOR_DIV_HI;
        xmit_cnt_next = xmit_cnt_reg + 7'h01;
        rcv_cnt_next = rcv_cnt_reg + 7'h01;
        xmit_tick_next = 1'b0;
        rcv_tick_next = 1'b0;
        if (xmit_cnt_reg >= xmit_div - 7'h01) begin
            xmit_cnt_next = 7'h00;
            xmit_tick_next = 1'b1;
        end
        if (rcv_cnt_reg >= rcv_div - 7'h01) begin
            rcv_cnt_next = 7'h00;
            rcv_tick_next = 1'b1;
        end
        if (!mr_sync_reg) begin
            xmit_cnt_next = 7'h00;
            rcv_cnt_next = 7'h00;
            xmit_tick_next = 1'b0;
            rcv_tick_next = 1'b0;
        end
    end

    // divider registers
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            xmit_cnt_reg <= 7'h00;
            rcv_cnt_reg <= 7'h00;
            xmit_tick_reg <= 1'b0;
            rcv_tick_reg <= 1'b0;
        end else begin
            xmit_cnt_reg <= xmit_cnt_next;
            rcv_cnt_reg <= rcv_cnt_next;
            xmit_tick_reg <= xmit_tick_next;
            rcv_tick_reg <= rcv_tick_next;
        end
    end

    // ************************************************************
    // word size, parity, loopback and half words
    // ************************************************************
    logic xmit_size_reg;
    logic xmit_size_next;
    logic [1:0] rcv_size_reg;
    logic [1:0] rcv_size_next;
    logic bit32_reg;
    logic bit32_next;
    logic [3:0] route_reg;
    logic [3:0] route_next;
    logic [2:0] xmit_pins_reg;
    logic [15:0] half_reg;
    logic [15:0] half_next;
    logic parity_calc;
    logic insert_parity;

    // size only switches at a word start so no word is cut short
    always_comb begin
        xmit_size_next = xmit_word_start ? opt_reg.word_size_pick : xmit_size_reg;
        rcv_size_next[0] = rcv_word_start[0] ? opt_reg.word_size_pick : rcv_size_reg[0];
        rcv_size_next[1] = rcv_word_start[1] ? opt_reg.word_size_pick : rcv_size_reg[1];
        // odd parity over the word body, inverted for even
        if (xmit_size_reg) begin
            parity_calc = ~(^xmit_word[23:0]);
        end else begin
            parity_calc = ~(^xmit_word[30:0]);
        end
        parity_calc = parity_calc ^ opt_reg.parity_polarity;
        insert_parity = gate_sync_reg || opt_reg.parity_insert_enable;
        if (insert_parity) begin
            bit32_next = parity_calc;
        end else if (xmit_size_reg) begin
            bit32_next = xmit_word[24];
        end else begin
            bit32_next = xmit_word[31];
        end
        // loopback bypasses line inputs, receiver two gets the complement
        if (!opt_reg.loopback_n) begin
            route_next = {~xmit_serial_b, xmit_serial_b, ~xmit_serial_a, xmit_serial_a};
        end else begin
            route_next = line_sync_reg;
        end
        // first half is low bits; short words keep nine high bits
        if (!rcv_half_pick) begin
            half_next = rcv_word_one[15:0];
        end else if (rcv_size_reg[0]) begin
            half_next = {7'h00, rcv_word_one[24:16]};
        end else begin
            half_next = rcv_word_one[31:16];
        end
    end

    // decode registers; transmitter pins always follow the core
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            xmit_size_reg <= 1'b0;
            rcv_size_reg <= 2'h0;
            bit32_reg <= 1'b0;
            route_reg <= 4'h0;
            xmit_pins_reg <= 3'h0;
            half_reg <= 16'h0000;
        end else begin
            xmit_size_reg <= xmit_size_next;
            rcv_size_reg <= rcv_size_next;
            bit32_reg <= bit32_next;
            route_reg <= route_next;
            xmit_pins_reg <= {xmit_clk_in, xmit_serial_b, xmit_serial_a};
            half_reg <= half_next;
        end
    end

    // ************************************************************
    // source/destination checks
    // ************************************************************
    alor_pkg::alor_match_t match_cfg [2];
    logic [31:0] rcv_words [2];

    assign match_cfg[0] = {opt_reg.rcv_one_match_en, opt_reg.rcv_one_code_hi,
                           opt_reg.rcv_one_code_lo};
    assign match_cfg[1] = {opt_reg.rcv_two_match_en, opt_reg.rcv_two_code_hi,
                           opt_reg.rcv_two_code_lo};
    assign rcv_words[0] = rcv_word_one;
    assign rcv_words[1] = rcv_word_two;

    // one checker per receiver
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_match
            alor_match_check u_match (
                .clk_sys(clk_sys),
                .arst_n(arst_n),
                .match_cfg(match_cfg[gi]),
                .word_done(rcv_word_done[gi]),
                .rcv_word(rcv_words[gi]),
                .accept(rcv_accept[gi])
            );
        end
    endgenerate

    // ************************************************************
    // outputs
    // ************************************************************
    assign rcv_in_a = route_reg[1:0];
    assign rcv_in_b = route_reg[3:2];
    assign xmit_pin_a = xmit_pins_reg[0];
    assign xmit_pin_b = xmit_pins_reg[1];
    assign xmit_clk_pin = xmit_pins_reg[2];
    assign xmit_bit_tick = xmit_tick_reg;
    assign rcv_sample_tick = rcv_tick_reg;
    assign xmit_size_short = xmit_size_reg;
    assign rcv_size_short = rcv_size_reg;
    assign xmit_bit32 = bit32_reg;
    assign half_word_out = half_reg;
    assign option_view = opt_reg;
endmodule

// >>> verif/alor_top_asserts.sv
// port checker for the link option register block
`timescale 1ns/1ns
module alor_top_asserts (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // host pins
    input wire logic [15:0] host_data_in,
    input wire logic option_load_n,
    input wire logic master_reset_n,
    // core side
    input wire logic xmit_serial_a,
    input wire logic xmit_serial_b,
    input wire logic xmit_clk_in,
    input wire logic xmit_word_start,
    input wire logic [1:0] rcv_word_start,
    input wire logic [1:0] rcv_word_done,
    input wire logic [31:0] rcv_word_one,
    input wire logic [31:0] rcv_word_two,
    // outputs
    input wire logic [1:0] rcv_in_a,
    input wire logic [1:0] rcv_in_b,
    input wire logic xmit_pin_a,
    input wire logic xmit_pin_b,
    input wire logic xmit_clk_pin,
    input wire logic xmit_bit_tick,
    input wire logic rcv_sample_tick,
    input wire logic xmit_size_short,
    input wire logic [1:0] rcv_size_short,
    input wire logic [1:0] rcv_accept,
    input wire alor_pkg::alor_option_t option_view
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    logic ok_one, ok_two, clean_reg, clean_next, rate_reg, rate_next;
    logic [6:0] gap_reg, gap_next;
    // ****
    // helper logic
    // ****
    // expected verdicts, and a gap count that is only trusted while rate and reset sit still
    always_comb begin
        ok_one = !option_view.rcv_one_match_en || (rcv_word_one[9:8] ==
            {option_view.rcv_one_code_hi, option_view.rcv_one_code_lo});
        ok_two = !option_view.rcv_two_match_en || (rcv_word_two[9:8] ==
            {option_view.rcv_two_code_hi, option_view.rcv_two_code_lo});
        rate_next = option_view.recv_rate_pick;
        gap_next = rcv_sample_tick ? 7'h00 : gap_reg + 7'h01;
        clean_next = (rcv_sample_tick || clean_reg) && master_reset_n && (rate_next == rate_reg);
    end
    // registers only
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            gap_reg <= 7'h00;
            clean_reg <= 1'b0;
            rate_reg <= 1'b0;
        end else begin
            gap_reg <= gap_next;
            clean_reg <= clean_next;
            rate_reg <= rate_next;
        end
    end
    sequence s_load_rise;
        $rose(option_load_n) && $stable(host_data_in);
    endsequence
    sequence s_strobe_quiet;
        option_load_n [*5];
    endsequence
    sequence s_loop_held;
        !option_view.loopback_n ##1 !option_view.loopback_n;
    endsequence
    // ****
    // assertions
    // ****
    chk_unused_zero: assert property (option_view.unused == 4'h0)
        else $error("option low bits not zero");
    chk_load_word: assert property (s_load_rise |-> ##[3:4]
        option_view == (host_data_in & 16'hFFF0)) else $error("option word not captured");
    chk_quiet_hold: assert property (s_strobe_quiet |=> $stable(option_view))
        else $error("option word moved without a load");
    chk_accept_one: assert property (rcv_word_done[0] |=> rcv_accept[0] == $past(ok_one))
        else $error("receiver one verdict wrong");
    chk_accept_two: assert property (rcv_word_done[1] |=> rcv_accept[1] == $past(ok_two))
        else $error("receiver two verdict wrong");
    chk_loop_one: assert property (s_loop_held |-> rcv_in_a == {~$past(xmit_serial_a),
        $past(xmit_serial_a)}) else $error("loopback rail a wrong");
    chk_loop_two: assert property (s_loop_held |-> rcv_in_b == {~$past(xmit_serial_b),
        $past(xmit_serial_b)}) else $error("loopback rail b wrong");
    chk_pins_follow: assert property ({xmit_pin_a, xmit_pin_b, xmit_clk_pin} ==
        $past({xmit_serial_a, xmit_serial_b, xmit_clk_in})) else $error("transmit pins silent");
    chk_xmit_size: assert property (xmit_word_start |=>
        xmit_size_short == $past(option_view.word_size_pick)) else $error("transmit size wrong");
    chk_rcv_size: assert property (rcv_word_start[0] |=>
        rcv_size_short[0] == $past(option_view.word_size_pick)) else $error("receive size wrong");
    // the rate seen one cycle before the tick is the one that timed it
    chk_rcv_period: assert property (rcv_sample_tick && clean_reg |->
        gap_reg == (rate_reg ? 7'h4F : 7'h09)) else $error("receive tick gap");
    // rate must still be high speed on the cycle that decides the next tick, ten cycles after the first
    chk_xmit_period: assert property (xmit_bit_tick && !option_view.xmit_rate_pick ##1
        (!xmit_bit_tick && master_reset_n && !option_view.xmit_rate_pick) [*8] ##1
        !option_view.xmit_rate_pick |=> xmit_bit_tick) else $error("transmit tick gap");
endmodule
bind alor_top alor_top_asserts u_asserts (.clk_sys(clk_sys), .arst_n(arst_n),
    .host_data_in(host_data_in), .option_load_n(option_load_n), .master_reset_n(master_reset_n),
    .xmit_serial_a(xmit_serial_a), .xmit_serial_b(xmit_serial_b), .xmit_clk_in(xmit_clk_in),
    .xmit_word_start(xmit_word_start), .rcv_word_start(rcv_word_start),
    .rcv_word_done(rcv_word_done), .rcv_word_one(rcv_word_one), .rcv_word_two(rcv_word_two),
    .rcv_in_a(rcv_in_a), .rcv_in_b(rcv_in_b), .xmit_pin_a(xmit_pin_a), .xmit_pin_b(xmit_pin_b),
    .xmit_clk_pin(xmit_clk_pin), .xmit_bit_tick(xmit_bit_tick),
    .rcv_sample_tick(rcv_sample_tick), .xmit_size_short(xmit_size_short),
    .rcv_size_short(rcv_size_short), .rcv_accept(rcv_accept), .option_view(option_view));

// >>> verif/alor_host_model.sv
// host processor model that loads the option word
`timescale 1ns/1ns
module alor_host_model (
    // clock
    input wire logic clk_sys,
    // option port
    output logic [15:0] host_data_in,
    output logic option_load_n
);
    // idle port at time zero
    initial begin
        host_data_in = 16'h0000;
        option_load_n = 1'b1;
    end
    // strobe low three clocks, data held past the rise so the synchroniser sees it settled
    task automatic load(input logic [15:0] w);
        @(posedge clk_sys);
        host_data_in <= w;
        option_load_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        option_load_n <= 1'b1;
        repeat (6) @(posedge clk_sys);
        host_data_in <= ~w; // released port must not show the old word
    endtask
endmodule

// >>> verif/alor_top_tb_top.sv
// self-checking bench for the link option register block
`timescale 1ns/1ns
module alor_top_tb_top;
    logic clk_sys, arst_n, parity_gate_n, master_reset_n, option_load_n, rcv_half_pick;
    logic xmit_serial_a, xmit_serial_b, xmit_clk_in, xmit_word_start, xmit_size_short;
    logic xmit_pin_a, xmit_pin_b, xmit_clk_pin, xmit_bit_tick, rcv_sample_tick, xmit_bit32;
    logic [15:0] host_data_in, half_word_out;
    logic [31:0] xmit_word, rcv_word_one, rcv_word_two, w;
    logic [1:0] line_rx_a, line_rx_b, rcv_word_start, rcv_word_done;
    logic [1:0] rcv_in_a, rcv_in_b, rcv_size_short, rcv_accept;
    alor_pkg::alor_option_t option_view;
    int err_total = 0;
    int checks_done = 0;
    int cyc = 0;
    int n;
    alor_host_model host (.clk_sys(clk_sys), .host_data_in(host_data_in),
        .option_load_n(option_load_n));
    alor_top DUT (.clk_sys(clk_sys), .arst_n(arst_n), .host_data_in(host_data_in),
        .option_load_n(option_load_n), .parity_gate_n(parity_gate_n),
        .master_reset_n(master_reset_n), .xmit_serial_a(xmit_serial_a),
        .xmit_serial_b(xmit_serial_b), .xmit_clk_in(xmit_clk_in), .xmit_word_start(xmit_word_start),
        .xmit_word(xmit_word), .line_rx_a(line_rx_a), .line_rx_b(line_rx_b),
        .rcv_word_start(rcv_word_start), .rcv_word_done(rcv_word_done),
        .rcv_word_one(rcv_word_one), .rcv_word_two(rcv_word_two), .rcv_half_pick(rcv_half_pick),
        .rcv_in_a(rcv_in_a), .rcv_in_b(rcv_in_b), .xmit_pin_a(xmit_pin_a), .xmit_pin_b(xmit_pin_b),
        .xmit_clk_pin(xmit_clk_pin), .xmit_bit_tick(xmit_bit_tick),
        .rcv_sample_tick(rcv_sample_tick), .xmit_size_short(xmit_size_short),
        .rcv_size_short(rcv_size_short), .xmit_bit32(xmit_bit32), .rcv_accept(rcv_accept),
        .half_word_out(half_word_out), .option_view(option_view));
    // ****
    // clock, timeout and helpers
    // ****
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    // ceiling well above the roughly 650 cycles the sequence needs
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            err_total++;
            finish_test();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("mismatches %0d checks %0d", err_total, checks_done);
        if (err_total == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk_sys);
    endtask
    // cycles between two rate ticks, sampled on the falling edge where they are settled
    task automatic period(input logic which, output int cnt);
        int k;
        k = 0;
        cnt = 0;
        while (k < 2 && cnt < 300) begin
            @(negedge clk_sys);
            cnt++;
            if ((which ? rcv_sample_tick : xmit_bit_tick) === 1'b1) begin
                k++;
                if (k == 1) cnt = 0;
            end
        end
    endtask
    // ****
    // main sequence
    // ****
    initial begin
        {arst_n, master_reset_n, parity_gate_n, rcv_half_pick} = 4'h6;
        {xmit_serial_a, xmit_serial_b, xmit_clk_in, xmit_word_start} = 4'h0;
        {xmit_word, rcv_word_one, rcv_word_two} = '0;
        {line_rx_a, line_rx_b, rcv_word_start, rcv_word_done} = 8'h00;
        w = 32'h8000_0001;
        tick(2);
        arst_n <= 1'b1;
        tick(2);
        chk(32'(option_view), 32'h0000_0020);
        host.load(16'hFFFF);
        chk(32'(option_view), 32'h0000_FFF0);
        master_reset_n <= 1'b0;
        tick(6);
        chk(32'(option_view), 32'h0000_FFF0);
        master_reset_n <= 1'b1;
        for (int s = 0; s < 2; s++) begin
            host.load({!s[0], 15'h0020});
            chk(32'(xmit_size_short), 32'(s[0]));
            {xmit_word_start, rcv_word_start, rcv_half_pick} <= 4'hE;
            rcv_word_one <= 32'hA5C3_1234;
            tick(1);
            {xmit_word_start, rcv_word_start} <= 3'h0;
            tick(2);
            chk(32'({xmit_size_short, rcv_size_short}), 32'({3{!s[0]}}));
            chk(32'(half_word_out), 32'h0000_1234);
            rcv_half_pick <= 1'b1;
            tick(2);
            chk(32'(half_word_out), s ? 32'h0000_A5C3 : 32'h0000_01C3);
        end
        for (int e = 0; e < 2; e++) begin
            host.load(e ? 16'h0AE0 : 16'h08A0);
            for (int k = 0; k < 4; k++) begin
                rcv_word_one <= {22'h0, k[1:0], 8'h00};
                rcv_word_two <= {22'h0, k[1:0], 8'h00};
                rcv_word_done <= 2'b11;
                tick(1);
                rcv_word_done <= 2'b00;
                @(negedge clk_sys);
                chk(32'(rcv_accept), 32'({!e || k == 2, !e || k == 1}));
                @(posedge clk_sys);
            end
        end
        xmit_word <= w;
        for (int i = 0; i < 4; i++) begin
            parity_gate_n <= !i[1];
            host.load({3'h0, !i[1] && i[0], 6'h00, 1'b1, i[1] && i[0], 4'h0});
            tick(2);
            chk(32'(xmit_bit32), 32'((i[1] && !i[0]) ? w[31] :
                ((~^w[30:0]) ^ (!i[1] && i[0]))));
        end
        host.load(16'h0000);
        for (int i = 0; i < 2; i++) begin
            {xmit_serial_a, xmit_serial_b, xmit_clk_in} <= {i[0], !i[0], 1'b1};
            {line_rx_a, line_rx_b} <= {i[0], !i[0], !i[0], i[0]};
            tick(3);
            chk(32'({rcv_in_a, rcv_in_b}), 32'({!i[0], i[0], i[0], !i[0]}));
            chk(32'({xmit_pin_a, xmit_pin_b, xmit_clk_pin}), 32'({i[0], !i[0], 1'b1}));
        end
        // ten null bit times at the high rate before leaving loopback
        {xmit_serial_a, xmit_serial_b} <= 2'b00;
        tick(100);
        host.load(16'h0020);
        chk(32'({rcv_in_a, rcv_in_b}), 32'h0000_0009);
        for (int r = 0; r < 2; r++) begin
            master_reset_n <= 1'b0;
            host.load({1'b0, r[0], r[0], 13'h0020});
            master_reset_n <= 1'b1;
            period(1'b0, n);
            chk(32'(n), r ? 32'h0000_0050 : 32'h0000_000A);
            period(1'b1, n);
            chk(32'(n), r ? 32'h0000_0050 : 32'h0000_000A);
        end
        finish_test();
    end
endmodule
